// ===== src/cal_status_pkg.sv
// Overview of operation
// - Self kind, code 00: DAC, gain, offset
// - Self kind: 01 gain+offset, 10 offset, 11 gain
// - System kind, code 00: DAC, gain, offset
// - System kind: 01 gain+offset, 10 offset, 11 gain
// - Status read after readback select 11
// - Status word reads 00C0h at power-up
// - Bits 15 and 13..10 read zero
// - Bit 14 busy on conversion or calibration
// - Bits 9..8 echo power-save selects
// - Bits 7 and 6 read one
// - Bit 5 interface flag, cleared per read
// - Bit 3 calibration kind, bit 4 undefined
// - Bit 0 set while calibrating
// - Bits 2..1 echo target-select code
// - Ten readable, writable coefficient registers
// - Calibration updates coefficients by itself
// - Target select addresses coefficients, both directions
// - Launch starts calibration, clears on completion
// - Launch zero: code addresses coefficients only
package cal_status_pkg;
    localparam logic [11:0] ADDR_CTRL      = 12'h000;
    localparam logic [11:0] ADDR_READBACK  = 12'h004;
    localparam logic [11:0] ADDR_CAL_DATA  = 12'h008;
    localparam int          BIT_LAUNCH     = 0;
    localparam int          BIT_TSEL_LO    = 1;
    localparam int          BIT_KIND       = 3;
    localparam int          BIT_CONV       = 4;
    localparam int          BIT_IFACE      = 5;
    localparam int          BIT_RSEL_LO    = 6;
    localparam int          BIT_PSAVE_LO   = 8;
    localparam int          ST_BUSY        = 14;
    localparam logic [1:0]  RSEL_CAL       = 2'h2;
    localparam logic [1:0]  RSEL_STATUS    = 2'h3;
    localparam logic [1:0]  TSEL_FULL      = 2'h0;
    localparam logic [1:0]  TSEL_GAIN_OFFS = 2'h1;
    localparam logic [1:0]  TSEL_OFFS      = 2'h2;
    localparam logic [1:0]  TSEL_GAIN      = 2'h3;
    localparam logic [3:0]  IDX_GAIN       = 4'h0;
    localparam logic [3:0]  IDX_OFFS       = 4'h1;
    localparam logic [3:0]  IDX_DAC0       = 4'h2;
    localparam logic [3:0]  CNT_FULL       = 4'hA;
    localparam logic [3:0]  CNT_PAIR       = 4'h2;
    localparam logic [3:0]  CNT_ONE        = 4'h1;
    localparam int          NUM_COEF       = 10;
    localparam int          COEF_W         = 14;
    localparam logic [15:0] CAL_STEP_CYC   = 16'h0040;
    localparam logic [15:0] CONV_CYC       = 16'h0010;
    localparam logic [15:0] STATUS_RESET   = 16'h0000;

    typedef enum logic [2:0] {
        PH_IDLE = 3'h0,
        PH_DAC  = 3'h1,
        PH_GAIN = 3'h3,
        PH_OFFS = 3'h2,
        PH_CONV = 3'h6
    } phase_t;
endpackage

// ===== src/cal_status_ctrl.sv
// The APB slave port and the address map were decided locally.
`timescale 1ns/1ps
module cal_status_ctrl #(
    parameter logic [15:0] STEP_CYCLES = cal_status_pkg::CAL_STEP_CYC,
    parameter logic [15:0] CONV_CYCLES = cal_status_pkg::CONV_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [13:0] meas_value,
    output logic             busy,
    output logic             cal_active,
    output logic             cal_system,
    output logic             cal_dac_step,
    output logic             cal_gain_step,
    output logic             cal_offs_step,
    output logic             conv_active,
    output logic [1:0]       power_save_sel,
    output logic             iface_variant
);
    typedef struct packed {
        logic [1:0]                    psave;
        logic [1:0]                    rsel;
        logic                          iface;
        logic                          kind;
        logic [1:0]                    tsel;
        cal_status_pkg::phase_t        ph;
        logic [2:0]                    dac_i;
        logic [15:0]                   cnt;
        logic [3:0]                    ptr;
        logic [3:0]                    left;
        logic [9:0][13:0]              coef;
        logic [31:0]                   rdata;
        logic                          err;
    } state_t;

    state_t s_r;
    state_t s_nxt;
    logic   setup;
    logic   done;
    logic   calib;
    logic   busy_i;
    logic [15:0] status;

    function automatic logic [3:0] seq_start(input logic [1:0] t);
        return (t == cal_status_pkg::TSEL_OFFS) ? cal_status_pkg::IDX_OFFS : cal_status_pkg::IDX_GAIN;
    endfunction

    function automatic logic [3:0] seq_len(input logic [1:0] t);
        case (t)
            cal_status_pkg::TSEL_FULL:      return cal_status_pkg::CNT_FULL;
            cal_status_pkg::TSEL_GAIN_OFFS: return cal_status_pkg::CNT_PAIR;
            default:                        return cal_status_pkg::CNT_ONE;
        endcase
    endfunction

    assign setup  = psel & ~penable;
    assign done   = psel & penable;
    assign calib  = (s_r.ph != cal_status_pkg::PH_IDLE) && (s_r.ph != cal_status_pkg::PH_CONV);
    assign busy_i = s_r.ph != cal_status_pkg::PH_IDLE;

    // Status word layout; bit 4 is don't-care and reads zero
    assign status = {1'b0, busy_i, 4'h0, s_r.psave, 2'b11, s_r.iface, 1'b0,
                     s_r.kind, s_r.tsel, calib};

    always_comb begin
        s_nxt = s_r;
        // Read data and error are decided in setup so they leave flops
        if (setup) begin
            s_nxt.rdata = 32'h0000_0000;
            s_nxt.err   = 1'b0;
            case (paddr)
                cal_status_pkg::ADDR_CTRL: begin
                    s_nxt.err = pwrite & busy_i;
                end
                cal_status_pkg::ADDR_READBACK: begin
                    s_nxt.err = pwrite;
                    if (s_r.rsel == cal_status_pkg::RSEL_STATUS) begin
                        s_nxt.rdata = {16'h0000, status};
                    end else if (s_r.rsel == cal_status_pkg::RSEL_CAL) begin
                        s_nxt.rdata = {18'h00000, s_r.coef[s_r.ptr]};
                    end
                end
                cal_status_pkg::ADDR_CAL_DATA: begin
                    s_nxt.err = ~pwrite | busy_i;
                end
                default: begin
                    s_nxt.err = 1'b1;
                end
            endcase
        end
        // Calibration and conversion sequencer
        case (s_r.ph)
            cal_status_pkg::PH_DAC: begin
                s_nxt.cnt = s_r.cnt + 16'h0001;
                if (s_r.cnt == STEP_CYCLES - 16'h0001) begin
                    s_nxt.cnt = 16'h0000;
                    s_nxt.coef[cal_status_pkg::IDX_DAC0 + {1'b0, s_r.dac_i}] = meas_value;
                    s_nxt.dac_i = s_r.dac_i + 3'h1;
                    if (s_r.dac_i == 3'h7) begin
                        s_nxt.ph = cal_status_pkg::PH_GAIN;
                    end
                end
            end
            cal_status_pkg::PH_GAIN: begin
                s_nxt.cnt = s_r.cnt + 16'h0001;
                if (s_r.cnt == STEP_CYCLES - 16'h0001) begin
                    s_nxt.cnt = 16'h0000;
                    s_nxt.coef[cal_status_pkg::IDX_GAIN] = meas_value;
                    s_nxt.ph = (s_r.tsel == cal_status_pkg::TSEL_GAIN) ? cal_status_pkg::PH_IDLE
                                                                       : cal_status_pkg::PH_OFFS;
                end
            end
            cal_status_pkg::PH_OFFS: begin
                s_nxt.cnt = s_r.cnt + 16'h0001;
                if (s_r.cnt == STEP_CYCLES - 16'h0001) begin
                    s_nxt.cnt = 16'h0000;
                    s_nxt.coef[cal_status_pkg::IDX_OFFS] = meas_value;
                    s_nxt.ph = cal_status_pkg::PH_IDLE;
                end
            end
            cal_status_pkg::PH_CONV: begin
                s_nxt.cnt = s_r.cnt + 16'h0001;
                if (s_r.cnt == CONV_CYCLES - 16'h0001) begin
                    s_nxt.cnt = 16'h0000;
                    s_nxt.ph  = cal_status_pkg::PH_IDLE;
                end
            end
            default: begin
                s_nxt.cnt = 16'h0000;
            end
        endcase
        // Access phase: effects take hold here, never in setup
        if (done && !s_r.err) begin
            if (pwrite && paddr == cal_status_pkg::ADDR_CTRL) begin
                s_nxt.psave = pwdata[cal_status_pkg::BIT_PSAVE_LO +: 2];
                s_nxt.rsel  = pwdata[cal_status_pkg::BIT_RSEL_LO +: 2];
                s_nxt.iface = pwdata[cal_status_pkg::BIT_IFACE];
                s_nxt.kind  = pwdata[cal_status_pkg::BIT_KIND];
                s_nxt.tsel  = pwdata[cal_status_pkg::BIT_TSEL_LO +: 2];
                s_nxt.ptr   = seq_start(pwdata[cal_status_pkg::BIT_TSEL_LO +: 2]);
                s_nxt.left  = seq_len(pwdata[cal_status_pkg::BIT_TSEL_LO +: 2]);
                s_nxt.cnt   = 16'h0000;
                s_nxt.dac_i = 3'h0;
                if (pwdata[cal_status_pkg::BIT_LAUNCH]) begin
                    case (pwdata[cal_status_pkg::BIT_TSEL_LO +: 2])
                        cal_status_pkg::TSEL_FULL:      s_nxt.ph = cal_status_pkg::PH_DAC;
                        cal_status_pkg::TSEL_GAIN_OFFS: s_nxt.ph = cal_status_pkg::PH_GAIN;
                        cal_status_pkg::TSEL_OFFS:      s_nxt.ph = cal_status_pkg::PH_OFFS;
                        default:                        s_nxt.ph = cal_status_pkg::PH_GAIN;
                    endcase
                end else if (pwdata[cal_status_pkg::BIT_CONV]) begin
                    s_nxt.ph = cal_status_pkg::PH_CONV;
                end
            end else begin
                if (!pwrite && paddr == cal_status_pkg::ADDR_READBACK) begin
                    s_nxt.iface = 1'b0;
                end
                // Coefficient pointer walks the selected run, then rewinds
                if ((pwrite && paddr == cal_status_pkg::ADDR_CAL_DATA) ||
                    (!pwrite && paddr == cal_status_pkg::ADDR_READBACK &&
                     s_r.rsel == cal_status_pkg::RSEL_CAL && !busy_i)) begin
                    if (pwrite) begin
                        s_nxt.coef[s_r.ptr] = pwdata[13:0];
                    end
                    if (s_r.left == 4'h1) begin
                        s_nxt.ptr  = seq_start(s_r.tsel);
                        s_nxt.left = seq_len(s_r.tsel);
                    end else begin
                        s_nxt.ptr  = s_r.ptr + 4'h1;
                        s_nxt.left = s_r.left - 4'h1;
                    end
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r       <= '0;
            s_r.ph    <= cal_status_pkg::PH_IDLE;
            s_r.left  <= cal_status_pkg::CNT_FULL;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata         = s_r.rdata;
    assign pslverr        = s_r.err & done;
    assign pready         = done;
    assign busy           = busy_i;
    assign cal_active     = calib;
    assign cal_system     = s_r.kind;
    assign cal_dac_step   = s_r.ph == cal_status_pkg::PH_DAC;
    assign cal_gain_step  = s_r.ph == cal_status_pkg::PH_GAIN;
    assign cal_offs_step  = s_r.ph == cal_status_pkg::PH_OFFS;
    assign conv_active    = s_r.ph == cal_status_pkg::PH_CONV;
    assign power_save_sel = s_r.psave;
    assign iface_variant  = s_r.iface;

    logic ctrl_wr;
    assign ctrl_wr = done && pwrite && !s_r.err && paddr == cal_status_pkg::ADDR_CTRL;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_STATUS_ZEROS: assert property (status[15] == 1'b0 && status[13:10] == 4'h0)
        else $error("status reserved bits not zero");
    AST_STATUS_ONES: assert property (status[7:6] == 2'b11)
        else $error("status select echo not 11");
    AST_BUSY_COVERS_CAL: assert property (cal_active |-> busy && status[0]
                                          && status[cal_status_pkg::ST_BUSY])
        else $error("busy not set during calibration");
    AST_FULL_SELF: assert property (ctrl_wr && pwdata[3:0] == 4'h1 |=> cal_dac_step && !cal_system)
        else $error("full self calibration did not start with DAC");
    AST_OFFS_ONLY: assert property (ctrl_wr && pwdata[3:0] == 4'h5 |=> cal_offs_step)
        else $error("offset-only self calibration wrong step");
    AST_FULL_SYS: assert property (ctrl_wr && pwdata[3:0] == 4'h9 |=> cal_dac_step && cal_system)
        else $error("full system calibration did not start with DAC");
    AST_GAIN_SYS: assert property (ctrl_wr && pwdata[3:0] == 4'hF && !busy |=> cal_gain_step [*2])
        else $error("system gain calibration not started");
    AST_NO_LAUNCH: assert property (ctrl_wr && pwdata[4:0] == 5'h04 |=> !busy && status[2:1] == 2'b10)
        else $error("address-only write started activity");
    AST_IFACE_CLEAR: assert property (done && !pwrite && !s_r.err && paddr == cal_status_pkg::ADDR_READBACK
                                      |=> !iface_variant)
        else $error("interface flag not cleared after read");
    AST_GAIN_UPDATE: assert property ($fell(cal_gain_step) && !ctrl_wr
                                      |-> s_r.coef[0] == $past(meas_value))
        else $error("gain coefficient not updated");
    AST_CAL_END: assert property ($fell(cal_active) |-> !busy && status[0] == 1'b0)
        else $error("calibration end not reported");
    AST_PSAVE_ECHO: assert property (ctrl_wr |=> status[9:8] == $past(pwdata[9:8]))
        else $error("power-save echo mismatch");
    AST_ECHO_KIND_TSEL: assert property (ctrl_wr |=> status[3:1] == $past(pwdata[3:1]))
        else $error("kind or target echo mismatch");
    AST_CAL_BIT: assert property (status[0] == (cal_dac_step || cal_gain_step || cal_offs_step))
        else $error("calibrating bit does not follow steps");
    AST_CONV_BUSY: assert property (conv_active |-> busy && !cal_active)
        else $error("conversion not reported busy");

    COV_FULL_CAL: cover property (cal_dac_step ##[1:600] cal_offs_step ##1 !busy);
    COV_CONVERSION: cover property (conv_active ##1 !busy);
    COV_REFUSED_CTRL: cover property (done && pwrite && pslverr && paddr == cal_status_pkg::ADDR_CTRL);
    COV_STATUS_READ: cover property (done && !pwrite && s_r.rsel == cal_status_pkg::RSEL_STATUS);
    COV_COEF_WRITE: cover property (done && pwrite && !s_r.err && paddr == cal_status_pkg::ADDR_CAL_DATA);
endmodule

// ===== verification/meas_source.sv
`timescale 1ns/1ps
// Converter front end: presents the sampled level on the next clock edge
module meas_source (
    input  wire logic        pclk,
    input  wire logic [13:0] level,
    output logic      [13:0] meas_value
);
    always_ff @(posedge pclk) begin
        meas_value <= level;
    end
endmodule

// ===== verification/tb_cal_status_ctrl.sv
`timescale 1ns/1ps
module tb_cal_status_ctrl;
    logic        pclk = 0;
    logic        presetn = 0;
    logic        psel = 0;
    logic        penable = 0;
    logic        pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, busy, cal_active, cal_system;
    logic        cal_dac_step, cal_gain_step, cal_offs_step, conv_active, iface_variant;
    logic [1:0]  power_save_sel;
    logic [13:0] level = 14'h0;
    logic [13:0] meas_value;
    logic [13:0] lev_g, lev_o, lev_d, va, vb;
    logic [31:0] seed = 32'h1A23;
    logic [33:0] e;
    logic [2:0]  prev = 3'h0;
    logic [33:0] exp_bus[$];
    logic [3:0]  exp_step[$];
    int          miscompares = 0;
    int          comparisons = 0;
    localparam logic [11:0] CTL = cal_status_pkg::ADDR_CTRL;
    localparam logic [11:0] RBK = cal_status_pkg::ADDR_READBACK;
    localparam logic [11:0] CDT = cal_status_pkg::ADDR_CAL_DATA;

    always #2 pclk = ~pclk;

    cal_status_ctrl #(.STEP_CYCLES(16'h0010), .CONV_CYCLES(16'h0010)) i_cal_status_ctrl (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .meas_value(meas_value), .busy(busy), .cal_active(cal_active), .cal_system(cal_system),
        .cal_dac_step(cal_dac_step), .cal_gain_step(cal_gain_step), .cal_offs_step(cal_offs_step),
        .conv_active(conv_active), .power_save_sel(power_save_sel), .iface_variant(iface_variant));
    meas_source i_meas_source (.pclk(pclk), .level(level), .meas_value(meas_value));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [31:0] ctl(logic [1:0] ps, logic [1:0] rs, logic ifc, logic cv,
                                        logic k, logic [1:0] t, logic l);
        return {22'h0, ps, rs, ifc, cv, k, t, l};
    endfunction
    function automatic logic [31:0] st(logic b, logic [1:0] ps, logic ifc, logic k, logic [1:0] t, logic c);
        return {16'h0, 1'b0, b, 4'h0, ps, 2'b11, ifc, 1'b0, k, t, c};
    endfunction

    task automatic end_of_test();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(string n, logic [32:0] seen, logic [32:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d, logic [33:0] ex);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        exp_bus.push_back(ex);
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            miscompares++;
            end_of_test();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(logic [11:0] a, logic [31:0] d, logic err);
        apb(1'b1, a, d, {1'b0, err, 32'h0});
    endtask
    task automatic rd(logic [11:0] a, logic [31:0] ex);
        apb(1'b0, a, 32'h0, {2'b10, ex});
    endtask
    task automatic wait_idle();
        int i;
        for (i = 0; i < 2000; i++) begin
            @(posedge pclk);
            if (busy === 1'b0) break;
        end
        if (i == 2000) begin
            miscompares++;
            end_of_test();
        end
    endtask

    // Result watcher: every completed access and every new calibration step
    always @(posedge pclk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            e = exp_bus.pop_front();
            if (e[33]) check("prdata", {pslverr, prdata}, e[32:0]);
            else check("pslverr", {32'h0, pslverr}, {32'h0, e[32]});
        end
        if (presetn === 1'b1 && {cal_dac_step, cal_gain_step, cal_offs_step} !== prev &&
            {cal_dac_step, cal_gain_step, cal_offs_step} !== 3'h0)
            check("step", {29'h0, cal_system, cal_dac_step, cal_gain_step, cal_offs_step},
                  {29'h0, exp_step.pop_front()});
        prev = {cal_dac_step, cal_gain_step, cal_offs_step};
    end

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        wr(CTL, ctl(2'b00, 2'b11, 0, 0, 0, 2'b00, 0), 0);
        rd(RBK, st(0, 2'b00, 0, 0, 2'b00, 0));
        wr(CTL, ctl(2'b10, 2'b11, 1, 0, 1, 2'b01, 0), 0);
        rd(RBK, st(0, 2'b10, 1, 1, 2'b01, 0));
        check("power_save_sel", {31'h0, power_save_sel}, 33'h2);
        rd(RBK, st(0, 2'b10, 0, 1, 2'b01, 0));
        check("iface_variant", {32'h0, iface_variant}, 33'h0);
        for (int k = 0; k < 2; k++) begin
            for (int t = 0; t < 4; t++) begin
                level <= 14'(xs());
                @(posedge pclk);
                if (t == 0) begin
                    exp_step.push_back({k[0], 3'b100});
                    lev_d = level;
                end
                if (t != 2) exp_step.push_back({k[0], 3'b010});
                if (t != 3) exp_step.push_back({k[0], 3'b001});
                if (t != 2) lev_g = level;
                if (t != 3) lev_o = level;
                wr(CTL, ctl(2'b00, 2'b11, 0, 0, k[0], t[1:0], 1), 0);
                rd(RBK, st(1, 2'b00, 0, k[0], t[1:0], 1));
                wr(CTL, ctl(2'b11, 2'b11, 0, 0, 0, 2'b00, 0), 1);
                check("busy", {32'h0, busy}, 33'h1);
                wait_idle();
                rd(RBK, st(0, 2'b00, 0, k[0], t[1:0], 0));
            end
        end
        // Coefficient reads and writes are never interleaved by this host
        wr(CTL, ctl(2'b00, cal_status_pkg::RSEL_CAL, 0, 0, 0, cal_status_pkg::TSEL_FULL, 0), 0);
        rd(RBK, {18'h0, lev_g});
        rd(RBK, {18'h0, lev_o});
        for (int i = 0; i < 8; i++) rd(RBK, {18'h0, lev_d});
        va = 14'(xs());
        vb = 14'(xs());
        wr(CTL, ctl(2'b00, cal_status_pkg::RSEL_CAL, 0, 0, 0, cal_status_pkg::TSEL_GAIN_OFFS, 0), 0);
        wr(CDT, {18'h0, va}, 0);
        wr(CDT, {18'h0, vb}, 0);
        wr(CTL, ctl(2'b00, cal_status_pkg::RSEL_CAL, 0, 0, 0, cal_status_pkg::TSEL_GAIN_OFFS, 0), 0);
        rd(RBK, {18'h0, va});
        rd(RBK, {18'h0, vb});
        wr(CTL, ctl(2'b00, cal_status_pkg::RSEL_CAL, 0, 0, 0, cal_status_pkg::TSEL_OFFS, 0), 0);
        rd(RBK, {18'h0, vb});
        wr(CTL, ctl(2'b00, cal_status_pkg::RSEL_CAL, 0, 0, 0, cal_status_pkg::TSEL_GAIN, 0), 0);
        rd(RBK, {18'h0, va});
        wr(RBK, 32'h0, 1);
        apb(1'b0, CDT, 32'h0, {2'b01, 32'h0});
        apb(1'b0, 12'h00C, 32'h0, {2'b01, 32'h0});
        wr(CTL, ctl(2'b01, 2'b11, 0, 1, 0, 2'b10, 0), 0);
        rd(RBK, st(1, 2'b01, 0, 0, 2'b10, 0));
        check("cal_active", {32'h0, cal_active}, 33'h0);
        check("conv_active", {32'h0, conv_active}, 33'h1);
        check("power_save_sel", {31'h0, power_save_sel}, 33'h1);
        wait_idle();
        rd(RBK, st(0, 2'b01, 0, 0, 2'b10, 0));
        check("conv_active", {32'h0, conv_active}, 33'h0);
        repeat (2) @(posedge pclk);
        check("queues", {1'b0, exp_bus.size() + exp_step.size()}, 33'h0);
        end_of_test();
    end
endmodule
